/* File: core/src_consts.svh */
// Register map, field positions, reset values and timing counts
`ifndef SRC_CONSTS_SVH
`define SRC_CONSTS_SVH

// Register byte addresses
`define SRC_ADDR_CTRL      8'h00
`define SRC_ADDR_CMD       8'h04
`define SRC_ADDR_STAT      8'h08
`define SRC_ADDR_OPT       8'h0C
`define SRC_ADDR_WAKE      8'h10

// Control register fields
`define SRC_CTRL_DIV_LSB   0
`define SRC_CTRL_DIV_MSB   3
`define SRC_CTRL_CER       4
`define SRC_CTRL_XTL       5
`define SRC_CTRL_RCO       6
`define SRC_CTRL_XSEL      7
`define SRC_CTRL_RST       8'h40

// Standby command bits
`define SRC_CMD_PAUSE      0
`define SRC_CMD_DEEP       1
`define SRC_CMD_XHOLD      2

// Status fields: causes [3:0], refused [4], oscillators [7:5], mode [11:8]
`define SRC_STAT_REFUSED   4

// Wake configuration: level detection for the first two external inputs
`define SRC_WAKE_A_LVL     0
`define SRC_WAKE_B_LVL     1
`define SRC_WAKE_RST       2'h0

// Divider settings; the shortest instruction cycle, 300 ns, is 3 clocks
`define SRC_DIV_MAX        4'h8
`define SRC_TCYC_BASE_CYC  3

// Bus responses
`define SRC_RESP_OKAY      2'h0
`define SRC_RESP_SLVERR    2'h2

`endif

/* File: core/src_pkg.sv */
// Types shared by the standby and reset controller
package src_pkg;

   typedef enum logic [3:0]
   {
      SRC_RUN   = 4'h1,
      SRC_PAUSE = 4'h2,
      SRC_DEEP  = 4'h4,
      SRC_XHOLD = 4'h8
   } src_mode_e;

   typedef logic [3:0] src_div_t;

endpackage

/* File: core/src_clk_div.sv */
// Instruction cycle divider: one tick every 3 * 2**sel clocks
`include "src_consts.svh"

module src_clk_div
(
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_arst_n,
   // Control
   input  wire logic         i_run,
   input  wire src_pkg::src_div_t i_sel,
   // Tick out
   output logic              o_tick
);
   import src_pkg::*;

   localparam logic [1:0] PHASE_LAST = 2'(`SRC_TCYC_BASE_CYC - 1);

   logic [7:0] pre_r;
   logic [1:0] phase_r;
   logic       tick_r;
   logic [3:0] sel_c;
   logic [8:0] mask_w;
   logic       pre_wrap;
   logic       phase_wrap;

   // Settings above the ninth are clamped to the slowest ratio
   assign sel_c      = (i_sel > `SRC_DIV_MAX) ? `SRC_DIV_MAX : i_sel;
   assign mask_w     = (9'h001 << sel_c) - 9'h001;
   assign pre_wrap   = (pre_r == mask_w[7:0]);
   assign phase_wrap = (phase_r == PHASE_LAST);
   assign o_tick     = tick_r;

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         pre_r   <= 8'h00;
         phase_r <= 2'h0;
         tick_r  <= 1'b0;
      end
      else
      begin
         pre_r   <= (!i_run || pre_wrap) ? 8'h00 : pre_r + 8'h01;
         if (!i_run)
            phase_r <= 2'h0;
         else if (pre_wrap)
            phase_r <= phase_wrap ? 2'h0 : phase_r + 2'h1;
         tick_r  <= i_run && pre_wrap && phase_wrap;
      end
   end

endmodule

/* File: core/src_standby_ctrl.sv */
// Standby, internal reset and system clock divider controller
//
// The AXI4-Lite register port and the address map were decided locally.
`include "src_consts.svh"

module src_standby_ctrl
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   // AXI4-Lite write channels
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [7:0]        i_awaddr,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   output logic [1:0]             o_bresp,
   // AXI4-Lite read channels
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   input  wire logic [7:0]        i_araddr,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   // Option straps
   input  wire logic [1:0]        i_opt_por_lvl,
   input  wire logic              i_opt_lvd_en,
   input  wire logic [1:0]        i_opt_lvd_lvl,
   // Pin and supply comparators (asynchronous)
   input  wire logic              i_external_reset_pin_n,
   input  wire logic [3:0]        i_por_above,
   input  wire logic [2:0]        i_lvd_above,
   // Reset and interrupt sources (same clock)
   input  wire logic              i_wdt_reset,
   input  wire logic              i_irq_any,
   input  wire logic              i_ext_irq_a,
   input  wire logic              i_ext_irq_b,
   input  wire logic              i_ext_irq_c,
   input  wire logic              i_ext_irq_e,
   input  wire logic              i_ext_irq_f,
   input  wire logic              i_port0_irq,
   input  wire logic              i_base_timer_irq,
   // System control outputs
   output logic                   o_sys_reset,
   output logic                   o_cpu_run,
   output logic                   o_periph_run,
   output logic                   o_base_timer_run,
   output logic                   o_ceramic_osc_en,
   output logic                   o_crystal_osc_en,
   output logic                   o_internal_resistor_cap_osc_en,
   output logic                   o_instr_tick,
   output logic                   o_wake_irq,
   output src_pkg::src_mode_e     o_mode
);
   import src_pkg::*;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == `SRC_ADDR_CTRL) || (a == `SRC_ADDR_CMD) ||
                  (a == `SRC_ADDR_STAT) || (a == `SRC_ADDR_OPT) ||
                  (a == `SRC_ADDR_WAKE);
   endfunction

   // Synchronisers and filtered levels
   logic [7:0]  raw_w;
   logic [7:0]  s1_r;
   logic [7:0]  s2_r;
   logic [7:0]  s3_r;
   logic [7:0]  flt_r;
   // Straps and reset state
   logic        opt_ok_r;
   logic [1:0]  opt_por_r;
   logic        opt_lvd_en_r;
   logic [1:0]  opt_lvd_r;
   logic        por_done_r;
   logic        sys_rst_r;
   logic [3:0]  cause_r;
   logic        refused_r;
   // Software state
   logic [7:0]  ctrl_r;
   logic [1:0]  wake_r;
   src_mode_e   mode_r;
   src_mode_e   mode_nxt;
   logic        wake_nxt;
   logic        refuse_nxt;
   // Registered outputs
   logic        cpu_run_r;
   logic        periph_run_r;
   logic        btm_run_r;
   logic        cer_r;
   logic        xtl_r;
   logic        rco_r;
   logic        wake_irq_r;
   // Bus slave state
   logic        awready_r;
   logic        wready_r;
   logic        aw_have_r;
   logic        w_have_r;
   logic [7:0]  waddr_r;
   logic [31:0] wdata_r;
   logic        wstrb0_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        arready_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;

   // Decoding
   logic        pin_low;
   logic [1:0]  lvd_idx;
   logic        lvd_low;
   logic        rst_cond;
   logic [3:0]  cause_set;
   logic        wr_go;
   logic        wr_ok;
   logic        wr_ctrl;
   logic        wr_cmd;
   logic        wr_stat;
   logic        wr_wake;
   logic        wake_deep;
   logic        wake_xhold;
   logic        xtal_ok;
   logic        div_run;
   logic [31:0] rd_mux;
   logic [11:0] stat_w;

   assign raw_w     = {i_lvd_above, i_por_above, i_external_reset_pin_n};
   assign pin_low   = ~flt_r[0];
   assign lvd_idx   = (opt_lvd_r == 2'h3) ? 2'h2 : opt_lvd_r;
   assign lvd_low   = opt_lvd_en_r && !flt_r[5 + lvd_idx];
   assign rst_cond  = !por_done_r || lvd_low || pin_low || i_wdt_reset;
   assign cause_set = {i_wdt_reset, pin_low && por_done_r,
                       lvd_low && por_done_r, !por_done_r};

   assign wr_go   = aw_have_r && w_have_r && !bvalid_r;
   // Control, command and wake writes act only while instructions run; status clears act in any mode
   assign wr_ok   = wr_go && wstrb0_r && (mode_r == SRC_RUN) && !sys_rst_r;
   assign wr_ctrl = wr_ok && (waddr_r == `SRC_ADDR_CTRL);
   assign wr_cmd  = wr_ok && (waddr_r == `SRC_ADDR_CMD);
   assign wr_stat = wr_go && wstrb0_r && (waddr_r == `SRC_ADDR_STAT);
   assign wr_wake = wr_ok && (waddr_r == `SRC_ADDR_WAKE);

   // edge-mode inputs a and b cannot wake
   assign wake_deep  = (i_ext_irq_a && wake_r[`SRC_WAKE_A_LVL]) ||
                       (i_ext_irq_b && wake_r[`SRC_WAKE_B_LVL]) ||
                       i_ext_irq_c || i_ext_irq_e || i_ext_irq_f ||
                       i_port0_irq;
   assign wake_xhold = wake_deep || i_base_timer_irq;
   // crystal must be the selected source
   assign xtal_ok    = ctrl_r[`SRC_CTRL_XSEL];
   assign div_run    = periph_run_r;

   assign stat_w = {mode_r, rco_r, xtl_r, cer_r, refused_r, cause_r};
   assign rd_mux =
      (i_araddr == `SRC_ADDR_CTRL) ? {24'h000000, ctrl_r} :
      (i_araddr == `SRC_ADDR_STAT) ? {20'h00000, stat_w} :
      (i_araddr == `SRC_ADDR_OPT)  ?
         {26'h0000000, opt_ok_r, opt_lvd_r, opt_lvd_en_r, opt_por_r} :
      (i_araddr == `SRC_ADDR_WAKE) ? {30'h00000000, wake_r} :
      32'h00000000;

   // Three-stage sampling; a level counts once stages two and three agree
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         s1_r  <= 8'h00;
         s2_r  <= 8'h00;
         s3_r  <= 8'h00;
         flt_r <= 8'h00;
      end
      else
      begin
         s1_r  <= raw_w;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         flt_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);
      end
   end

   // straps caught once after release, fixed until power-off
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         opt_ok_r     <= 1'b0;
         opt_por_r    <= 2'h0;
         opt_lvd_en_r <= 1'b0;
         opt_lvd_r    <= 2'h0;
      end
      else if (!opt_ok_r)
      begin
         opt_ok_r     <= 1'b1;
         opt_por_r    <= i_opt_por_lvl;
         opt_lvd_en_r <= i_opt_lvd_en;
         opt_lvd_r    <= i_opt_lvd_lvl;
      end
   end

   // power-on release is one-shot; only power-off rearms it
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         por_done_r <= 1'b0;
      else if (opt_ok_r && flt_r[1 + opt_por_r])
         por_done_r <= 1'b1;
   end

   // Reset causes and refused request are sticky; set beats clear
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         sys_rst_r <= 1'b1;
         cause_r   <= 4'h0;
         refused_r <= 1'b0;
      end
      else
      begin
         sys_rst_r <= rst_cond;
         cause_r   <= cause_set |
                      (cause_r & ~(wr_stat ? wdata_r[3:0] : 4'h0));
         refused_r <= refuse_nxt ||
                      (refused_r &&
                       !(wr_stat && wdata_r[`SRC_STAT_REFUSED]));
      end
   end

   // system reset stops ceramic and crystal oscillators
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ctrl_r <= `SRC_CTRL_RST;
         wake_r <= `SRC_WAKE_RST;
      end
      else if (sys_rst_r)
      begin
         ctrl_r <= `SRC_CTRL_RST;
         wake_r <= `SRC_WAKE_RST;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_r <= wdata_r[7:0];
         if (wr_wake)
            wake_r <= wdata_r[1:0];
      end
   end

   // Standby mode sequencing
   always_comb
   begin
      mode_nxt   = mode_r;
      wake_nxt   = 1'b0;
      refuse_nxt = 1'b0;
      // any reset returns through the full reset sequence
      if (rst_cond)
         mode_nxt = SRC_RUN;
      else
      begin
         unique case (mode_r)
            SRC_RUN:
            begin
               if (wr_cmd && wdata_r[`SRC_CMD_DEEP])
                  mode_nxt = SRC_DEEP;
               else if (wr_cmd && wdata_r[`SRC_CMD_XHOLD])
               begin
                  if (xtal_ok)
                     mode_nxt = SRC_XHOLD;
                  else
                     refuse_nxt = 1'b1;
               end
               else if (wr_cmd && wdata_r[`SRC_CMD_PAUSE])
                  mode_nxt = SRC_PAUSE;
            end
            SRC_PAUSE:
            begin
               if (i_irq_any)
               begin
                  mode_nxt = SRC_RUN;
                  wake_nxt = 1'b1;
               end
            end
            SRC_DEEP:
            begin
               if (wake_deep)
               begin
                  mode_nxt = SRC_RUN;
                  wake_nxt = 1'b1;
               end
            end
            SRC_XHOLD:
            begin
               // deep sleep sources plus base timer
               if (wake_xhold)
               begin
                  mode_nxt = SRC_RUN;
                  wake_nxt = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         mode_r <= SRC_RUN;
      else
         mode_r <= mode_nxt;
   end

   // Run enables and oscillator gating, registered from the next mode
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cpu_run_r    <= 1'b0;
         periph_run_r <= 1'b0;
         btm_run_r    <= 1'b0;
         cer_r        <= 1'b0;
         xtl_r        <= 1'b0;
         rco_r        <= 1'b0;
         wake_irq_r   <= 1'b0;
      end
      else
      begin
         cpu_run_r    <= !rst_cond && (mode_nxt == SRC_RUN);
         periph_run_r <= !rst_cond &&
                         (mode_nxt == SRC_RUN || mode_nxt == SRC_PAUSE);
         // base timer alone runs in crystal sleep
         btm_run_r    <= !rst_cond && (mode_nxt != SRC_DEEP);
         cer_r        <= ctrl_r[`SRC_CTRL_CER] && !rst_cond && !sys_rst_r &&
                         mode_nxt != SRC_DEEP && mode_nxt != SRC_XHOLD;
         xtl_r        <= ctrl_r[`SRC_CTRL_XTL] && !rst_cond && !sys_rst_r &&
                         mode_nxt != SRC_DEEP;
         // RC stops in both sleeps; pause leaves it alone
         rco_r        <= ctrl_r[`SRC_CTRL_RCO] &&
                         mode_nxt != SRC_DEEP && mode_nxt != SRC_XHOLD;
         // interrupt wake hands the interrupt to the CPU
         wake_irq_r   <= wake_nxt;
      end
   end

   // instruction cycle from the control divider field
   // ratios 1 to 256 in powers of two
   src_clk_div u_div
   (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_run    (div_run),
      .i_sel    (ctrl_r[`SRC_CTRL_DIV_MSB:`SRC_CTRL_DIV_LSB]),
      .o_tick   (o_instr_tick)
   );

   // Write path: address and data taken in either order
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         waddr_r   <= 8'h00;
         wdata_r   <= 32'h00000000;
         wstrb0_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `SRC_RESP_OKAY;
      end
      else
      begin
         if (i_awvalid && awready_r)
         begin
            awready_r <= 1'b0;
            aw_have_r <= 1'b1;
            waddr_r   <= i_awaddr;
         end
         if (i_wvalid && wready_r)
         begin
            wready_r <= 1'b0;
            w_have_r <= 1'b1;
            wdata_r  <= i_wdata;
            wstrb0_r <= i_wstrb[0];
         end
         if (wr_go)
         begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= is_mapped(waddr_r) ? `SRC_RESP_OKAY
                                            : `SRC_RESP_SLVERR;
         end
         else if (bvalid_r && i_bready)
         begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // Read path: one read in flight, data sampled at acceptance
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h00000000;
         rresp_r   <= `SRC_RESP_OKAY;
      end
      else if (i_arvalid && arready_r)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= rd_mux;
         rresp_r   <= is_mapped(i_araddr) ? `SRC_RESP_OKAY
                                          : `SRC_RESP_SLVERR;
      end
      else if (rvalid_r && i_rready)
      begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   assign o_awready        = awready_r;
   assign o_wready         = wready_r;
   assign o_bvalid         = bvalid_r;
   assign o_bresp          = bresp_r;
   assign o_arready        = arready_r;
   assign o_rvalid         = rvalid_r;
   assign o_rdata          = rdata_r;
   assign o_rresp          = rresp_r;
   assign o_sys_reset      = sys_rst_r;
   assign o_cpu_run        = cpu_run_r;
   assign o_periph_run     = periph_run_r;
   assign o_base_timer_run = btm_run_r;
   assign o_ceramic_osc_en = cer_r;
   assign o_crystal_osc_en = xtl_r;
   assign o_internal_resistor_cap_osc_en = rco_r;
   assign o_wake_irq       = wake_irq_r;
   assign o_mode           = mode_r;

endmodule

/* File: verif/src_far_model.sv */
// Far side model: supply comparators and pending interrupt sources
module src_far_model
(
   // Clock and bench control
   input  wire logic        i_clk,
   input  wire logic [12:0] i_mv,
   input  wire logic [7:0]  i_set,
   input  wire logic        i_clr,
   // Towards the controller
   output logic [3:0]       o_por_above,
   output logic [2:0]       o_lvd_above,
   output logic [7:0]       o_irq
);
   // Comparator trip points in millivolts, lowest level first
   assign o_por_above = {i_mv >= 13'h10FE, i_mv >= 13'hF14,
                         i_mv >= 13'hB36, i_mv >= 13'hA0A};
   assign o_lvd_above = {i_mv >= 13'h10B8, i_mv >= 13'hECE,
                         i_mv >= 13'hAFA};

   // A request stays pending until serviced; a new request wins
   always_ff @(posedge i_clk)
      o_irq <= (o_irq & ~{8{i_clr}}) | i_set;
endmodule

/* File: verif/src_standby_chk.sv */
// Port-level assertions for the standby and reset controller
module src_standby_chk
(
   // Clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_arst_n,
   // Write handshake
   input  wire logic               i_awvalid,
   input  wire logic               o_awready,
   input  wire logic               i_wvalid,
   input  wire logic               o_wready,
   input  wire logic               o_bvalid,
   // Wake sources
   input  wire logic               i_ext_irq_c,
   input  wire logic               i_ext_irq_e,
   input  wire logic               i_ext_irq_f,
   input  wire logic               i_port0_irq,
   input  wire logic               i_base_timer_irq,
   // System control
   input  wire logic               o_sys_reset,
   input  wire logic               o_cpu_run,
   input  wire logic               o_periph_run,
   input  wire logic               o_base_timer_run,
   input  wire logic               o_ceramic_osc_en,
   input  wire logic               o_crystal_osc_en,
   input  wire logic               o_internal_resistor_cap_osc_en,
   input  wire logic               o_instr_tick,
   input  wire logic               o_wake_irq,
   input  wire src_pkg::src_mode_e o_mode
);
   import src_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);
   wire logic [2:0] osc_w = {o_ceramic_osc_en, o_crystal_osc_en,
                             o_internal_resistor_cap_osc_en};
   wire logic       src_w = i_ext_irq_c | i_ext_irq_e | i_ext_irq_f
                            | i_port0_irq;

   pause_run_a:
      assert property (o_mode == SRC_PAUSE |-> o_periph_run && !o_cpu_run)
      else $error("pause run state wrong");
   pause_osc_a:
      assert property (o_mode == SRC_PAUSE |-> $stable(osc_w))
      else $error("pause moved an oscillator");
   deep_stop_a:
      assert property (o_mode == SRC_DEEP |-> !o_cpu_run && !o_periph_run
                       && !o_base_timer_run)
      else $error("deep sleep left something running");
   deep_osc_a:
      assert property (o_mode == SRC_DEEP |-> osc_w == 3'h0)
      else $error("deep sleep oscillator on");
   deep_wake_a:
      assert property (o_mode == SRC_DEEP && src_w |=> o_mode == SRC_RUN)
      else $error("deep sleep missed a wake");
   xhold_run_a:
      assert property (o_mode == SRC_XHOLD |-> o_base_timer_run && !o_cpu_run
                       && !o_periph_run && !o_internal_resistor_cap_osc_en)
      else $error("crystal sleep run state wrong");
   xtal_hold_a:
      assert property (o_mode == SRC_XHOLD |-> $stable(o_crystal_osc_en))
      else $error("crystal enable changed in sleep");
   xhold_wake_a:
      assert property (o_mode == SRC_XHOLD && (src_w || i_base_timer_irq)
                       |=> o_mode == SRC_RUN)
      else $error("crystal sleep missed a wake");
   wake_run_a:
      assert property (o_wake_irq |-> o_mode == SRC_RUN && o_cpu_run)
      else $error("wake pulse without running CPU");
   reset_osc_a:
      assert property ($fell(o_sys_reset) |-> !o_ceramic_osc_en
                       && !o_crystal_osc_en)
      else $error("oscillator on after reset");
   tick_gap_a:
      assert property (o_instr_tick |=> !o_instr_tick [*2])
      else $error("instruction ticks too close");
   write_resp_a:
      assert property (i_awvalid && o_awready && i_wvalid && o_wready
                       |=> !o_bvalid ##1 o_bvalid)
      else $error("write response timing wrong");
endmodule

bind src_standby_ctrl src_standby_chk u_chk (.*);

/* File: verif/test_standby_reset_control.sv */
// Self-checking bench for the standby and reset controller
`include "src_consts.svh"

module test_standby_reset_control;
   timeunit 1ns;
   timeprecision 1ns;
   import src_pkg::*;
   logic        i_clk = 1'b0, i_arst_n = 1'b0;
   logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic        i_arvalid = 1'b0, i_rready = 1'b0;
   logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
   logic [31:0] i_wdata = 32'h0, rd, o_rdata;
   logic [3:0]  i_wstrb = 4'hF, i_por_above;
   logic [1:0]  i_opt_por_lvl, i_opt_lvd_lvl, rsp, o_bresp, o_rresp;
   logic        i_opt_lvd_en = 1'b1, i_external_reset_pin_n = 1'b1;
   logic        i_wdt_reset = 1'b0, clr0 = 1'b1;
   logic [12:0] mv = 13'h1388;
   logic [7:0]  set = 8'h00, irq;
   logic [2:0]  i_lvd_above;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic        o_sys_reset, o_cpu_run, o_periph_run, o_base_timer_run;
   logic        o_ceramic_osc_en, o_crystal_osc_en, o_instr_tick, o_wake_irq;
   logic        o_internal_resistor_cap_osc_en;
   src_mode_e   o_mode;
   int          bad_count = 0, n_tests = 0;
   // Trip points in millivolts; brownout index 3 behaves as 2
   logic [12:0] por_mv [4] = '{13'hA0A, 13'hB36, 13'hF14, 13'h10FE};
   logic [12:0] lvd_mv [4] = '{13'hAFA, 13'hECE, 13'h10B8, 13'h10B8};
   wire logic i_ext_irq_a = irq[0], i_ext_irq_b = irq[1];
   wire logic i_ext_irq_c = irq[2], i_ext_irq_e = irq[3];
   wire logic i_ext_irq_f = irq[4], i_port0_irq = irq[5];
   wire logic i_base_timer_irq = irq[6], i_irq_any = |irq;

   src_standby_ctrl dut (.*);
   src_far_model far (.i_clk(i_clk), .i_mv(mv), .i_set(set),
      .i_clr(o_wake_irq | clr0), .o_por_above(i_por_above),
      .o_lvd_above(i_lvd_above), .o_irq(irq));

   initial
   begin
      forever #50 i_clk = ~i_clk;
   end

   function automatic logic [31:0] exp_gap(input logic [3:0] d);
      return 32'h3 << (d > 4'h8 ? 4'h8 : d);
   endfunction

   function automatic logic [31:0] exp_opt();
      return {26'h0, 1'b1, i_opt_lvd_lvl, i_opt_lvd_en, i_opt_por_lvl};
   endfunction

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("FAIL t=%0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic mode_is(input src_mode_e m);
      chk({28'h0, o_mode}, {28'h0, m});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_awvalid <= 1'b1;
      i_awaddr <= a;
      i_wvalid <= 1'b1;
      i_wdata <= d;
      i_bready <= 1'b1;
      do
      begin
         @(posedge i_clk);
         if (i_awvalid && o_awready)
            i_awvalid <= 1'b0;
         if (i_wvalid && o_wready)
            i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1);
      i_bready <= 1'b0;
      rsp = o_bresp;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge i_clk);
      i_arvalid <= 1'b1;
      i_araddr <= a;
      i_rready <= 1'b1;
      do
      begin
         @(posedge i_clk);
         if (i_arvalid && o_arready)
            i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1);
      i_rready <= 1'b0;
      rd = o_rdata;
      rsp = o_rresp;
   endtask

   // First gap after a divider change may be partial, so skip it
   task automatic gap(input logic [3:0] d);
      int n = 0;
      wr(`SRC_ADDR_CTRL, {24'h0, 4'h4, d});
      repeat (2)
      begin
         @(posedge i_clk);
         while (o_instr_tick !== 1'b1) @(posedge i_clk);
      end
      do
      begin
         @(posedge i_clk);
         n++;
      end while (o_instr_tick !== 1'b1);
      chk(32'(n), exp_gap(d));
   endtask

   task automatic raise(input int b);
      @(posedge i_clk);
      set <= 8'h01 << b;
      @(posedge i_clk);
      set <= 8'h00;
   endtask

   task automatic woke();
      while (o_wake_irq !== 1'b1) @(posedge i_clk);
      mode_is(SRC_RUN);
      chk({31'h0, o_cpu_run}, 32'h1);
   endtask

   task automatic wait_sys(input logic v);
      while (o_sys_reset !== v) @(posedge i_clk);
   endtask

   initial
   begin
      void'($urandom(32'hFE9BCBD1));
      i_opt_por_lvl <= 2'($urandom);
      i_opt_lvd_lvl <= 2'($urandom);
      repeat (3) @(posedge i_clk);
      i_arst_n <= 1'b1;
      clr0 <= 1'b0;
      wait_sys(1'b0);
      rd_reg(`SRC_ADDR_OPT);
      chk(rd, exp_opt());
      rd_reg(`SRC_ADDR_CTRL);
      chk(rd, 32'h40);
      rd_reg(8'h44);
      chk(32'(rsp), 32'(`SRC_RESP_SLVERR));
      wr(8'h44, 32'h0);
      chk(32'(rsp), 32'(`SRC_RESP_SLVERR));
      gap(4'h0);
      gap(4'h8);
      gap(4'($urandom));
      wr(`SRC_ADDR_CTRL, 32'h50);
      wr(`SRC_ADDR_CMD, 32'h1);
      mode_is(SRC_PAUSE);
      chk({29'h0, o_periph_run, o_cpu_run, o_ceramic_osc_en},
          32'h5);
      raise(7);
      woke();
      // Input a is edge-configured here, so it must not wake
      wr(`SRC_ADDR_CMD, 32'h2);
      chk({26'h0, o_cpu_run, o_periph_run, o_base_timer_run,
           o_ceramic_osc_en, o_crystal_osc_en,
           o_internal_resistor_cap_osc_en}, 32'h0);
      raise(0);
      repeat (10) @(posedge i_clk);
      mode_is(SRC_DEEP);
      raise(2);
      woke();
      wr(`SRC_ADDR_WAKE, 32'h3);
      for (int i = 0; i < 6; i++)
      begin
         wr(`SRC_ADDR_CMD, 32'h2);
         raise(i);
         woke();
      end
      wr(`SRC_ADDR_CTRL, 32'h60);
      wr(`SRC_ADDR_CMD, 32'h4);
      mode_is(SRC_RUN);
      rd_reg(`SRC_ADDR_STAT);
      chk({31'h0, rd[`SRC_STAT_REFUSED]}, 32'h1);
      wr(`SRC_ADDR_CTRL, 32'hE0);
      wr(`SRC_ADDR_CMD, 32'h4);
      mode_is(SRC_XHOLD);
      chk({29'h0, o_base_timer_run, o_crystal_osc_en,
           o_internal_resistor_cap_osc_en}, 32'h6);
      raise(6);
      woke();
      wr(`SRC_ADDR_CMD, 32'h2);
      i_wdt_reset <= 1'b1;
      @(posedge i_clk);
      i_wdt_reset <= 1'b0;
      wait_sys(1'b1);
      mode_is(SRC_RUN);
      wait_sys(1'b0);
      rd_reg(`SRC_ADDR_CTRL);
      chk(rd, 32'h40);
      wr(`SRC_ADDR_CMD, 32'h1);
      i_external_reset_pin_n <= 1'b0;
      wait_sys(1'b1);
      mode_is(SRC_RUN);
      i_external_reset_pin_n <= 1'b1;
      wait_sys(1'b0);
      mv <= lvd_mv[i_opt_lvd_lvl] + 13'h14;
      repeat (20) @(posedge i_clk);
      chk({31'h0, o_sys_reset}, 32'h0);
      mv <= lvd_mv[i_opt_lvd_lvl] - 13'h14;
      wait_sys(1'b1);
      mv <= 13'h1388;
      wait_sys(1'b0);
      // Second power-up with brownout off, supply under release level
      i_arst_n <= 1'b0;
      i_opt_lvd_en <= 1'b0;
      mv <= por_mv[i_opt_por_lvl] - 13'h14;
      repeat (3) @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (20) @(posedge i_clk);
      chk({31'h0, o_sys_reset}, 32'h1);
      mv <= 13'h1388;
      wait_sys(1'b0);
      mv <= 13'h7D0;
      repeat (30) @(posedge i_clk);
      chk({31'h0, o_sys_reset}, 32'h0);
      tally_and_finish();
   end

   initial
   begin
      repeat (20000) @(posedge i_clk);
      bad_count++;
      $display("FAIL t=%0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
